// ===== src/nbcp_pkg.sv
/*
  package of the flash host controller: command codes, address layout,
  strobe timing counts and bus widths.
  assumes one 125 MHz clock and a flash part on the documented pins.
*/
// Overview of operation
// - command byte on write strobe rise: cs low, cmd latch high, addr latch low.
// - address with addr latch high; data-in with both latches low.
// - program and erase rejected while write protect low; host holds it low except during program, erase and copy back.
// - four address cycles: A0-7, A9-16, A17-24, then A25 with bits 1-7 low.
// - program is 80h then 10h, erase 60h then D0h, address between.
// - in the 16-bit variant the host never issues 01h.
// - a pointer code may precede 80h and applies to the program.
package nbcp_pkg;
  localparam int unsigned BUS_W = 16;
  localparam int unsigned ADDR_W = 26;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned STROBE_LOW_NS = 25;
  localparam int unsigned STROBE_HIGH_NS = 15;
  localparam int unsigned STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [7:0] CMD_READ_A = 8'h00;
  localparam logic [7:0] CMD_READ_B = 8'h01;
  localparam logic [7:0] CMD_READ_C = 8'h50;
  localparam logic [7:0] CMD_SIG = 8'h90;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_PROG = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_COPY = 8'h8a;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam int unsigned COL_LSB = 0;
  localparam int unsigned CYC2_LSB = 9;
  localparam int unsigned CYC3_LSB = 17;
  localparam int unsigned TOP_BIT = 25;
  localparam int unsigned PAGE_LSB = 9;
  localparam int unsigned BLOCK_LSB = 14;
  // operation requested by the user side
  typedef enum logic [2:0] {
    NBCP_OP_READ, NBCP_OP_PROG, NBCP_OP_ERASE, NBCP_OP_COPY,
    NBCP_OP_SIG, NBCP_OP_STATUS, NBCP_OP_RESET
  } nbcp_op_type;
  typedef enum logic [1:0] {NBCP_AREA_A, NBCP_AREA_B, NBCP_AREA_C} nbcp_area_type;
endpackage

// ===== src/nbcp_mem.sv
/*
  small register-output memory used as fifo storage.
  assumes single clock, one write and one read port.
*/
module nbcp_mem #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW = $clog2(DEPTH)
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_reg
);
  logic [WIDTH-1:0] store_reg [DEPTH];

  // write port
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      store_reg[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge core_clk) begin
    rd_data_reg <= store_reg[rd_addr];
  end
endmodule

// ===== src/nbcp_fifo.sv
/*
  valid/ready fifo with parameter width and depth, show-ahead output.
  assumes single clock, asynchronous active-low reset.
*/
module nbcp_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic [AW-1:0] rd_addr;
  logic push;
  logic pop;

  // honest full and empty from the fill count
  assign in_ready = (cnt_reg < (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // read ahead so the head word is registered after a pop
  assign rd_addr = pop ? rp_reg + AW'(1) : rp_reg;

  // pointers and count
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= wp_reg + AW'(1);
      end
      if (pop) begin
        rp_reg <= rp_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  logic [WIDTH-1:0] mem_q;
  logic [WIDTH-1:0] bypass_reg;
  logic use_bypass_reg;

  nbcp_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
    .core_clk(core_clk),
    .wr_en(push),
    .wr_addr(wp_reg),
    .wr_data(in_data),
    .rd_addr(rd_addr),
    .rd_data_reg(mem_q)
  );

  // bypass when the word read is written in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      use_bypass_reg <= 1'b0;
      bypass_reg <= '0;
    end else begin
      use_bypass_reg <= push && (wp_reg == rd_addr);
      bypass_reg <= in_data;
    end
  end

  assign out_data = use_bypass_reg ? bypass_reg : mem_q;
endmodule

// ===== src/nbcp_host.sv
/*
  host controller for a page-organised flash part: issues command, address,
  data-in and data-out bus cycles by driving strobes from core_clk.
  assumes the part's pins are wired straight to the ports, io bus as
  three signals, inputs synchronous to core_clk.
*/
module nbcp_host (
  input wire logic core_clk,
  input wire logic rstn,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire nbcp_pkg::nbcp_op_type req_op,
  input wire nbcp_pkg::nbcp_area_type req_area,
  input wire logic [nbcp_pkg::ADDR_W-1:0] req_addr,
  input wire logic [8:0] req_count,
  input wire logic wide_bus,
  // write data toward the part
  input wire logic wdata_valid,
  output logic wdata_ready,
  input wire logic [nbcp_pkg::BUS_W-1:0] wdata,
  // read data from the part
  output logic rdata_valid,
  input wire logic rdata_ready,
  output logic [nbcp_pkg::BUS_W-1:0] rdata,
  output logic busy,
  output logic done,
  output logic wp_refused,
  // flash pins
  output logic chip_sel_n,
  output logic cmd_latch_en,
  output logic addr_latch_en,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic write_prot_n,
  input wire logic ready_busy_n,
  input wire logic [nbcp_pkg::BUS_W-1:0] io_in,
  output logic [nbcp_pkg::BUS_W-1:0] io_out_reg,
  output logic io_oe
);
  typedef enum logic [3:0] {
    S_IDLE, S_PTR, S_CMD1, S_ADDR, S_DIN, S_CMD2, S_WAIT, S_DOUT, S_DONE
  } nbcp_state_type;

  nbcp_state_type state_reg;
  nbcp_pkg::nbcp_op_type op_reg;
  nbcp_pkg::nbcp_area_type area_reg;
  logic [nbcp_pkg::ADDR_W-1:0] addr_reg;
  logic [8:0] count_reg;
  logic [1:0] acyc_reg;
  logic [2:0] ph_reg;
  logic strobe_low_reg;
  logic cle_reg;
  logic ale_reg;
  logic wr_n_reg;
  logic rd_n_reg;
  logic cs_n_reg;
  logic wp_n_reg;
  logic oe_reg;
  logic done_reg;
  logic refused_reg;
  logic rb_seen_reg;
  logic copy_tgt_reg;

  // timing of one bus cycle: low phase then high phase
  localparam logic [2:0] LOW_CYC = 3'(nbcp_pkg::STROBE_LOW_CYC);
  localparam logic [2:0] HIGH_CYC = 3'(nbcp_pkg::STROBE_HIGH_CYC);
  logic ph_end;
  logic cycle_end;
  assign ph_end = strobe_low_reg ? (ph_reg == LOW_CYC - 3'(1)) : (ph_reg == HIGH_CYC - 3'(1));
  assign cycle_end = ph_end && !strobe_low_reg;

  // first command byte for an operation
  function automatic logic [7:0] first_code(input nbcp_pkg::nbcp_op_type op);
    case (op)
      nbcp_pkg::NBCP_OP_PROG: first_code = nbcp_pkg::CMD_PROG;
      nbcp_pkg::NBCP_OP_ERASE: first_code = nbcp_pkg::CMD_ERASE;
      nbcp_pkg::NBCP_OP_SIG: first_code = nbcp_pkg::CMD_SIG;
      nbcp_pkg::NBCP_OP_STATUS: first_code = nbcp_pkg::CMD_STATUS;
      nbcp_pkg::NBCP_OP_RESET: first_code = nbcp_pkg::CMD_RESET;
      default: first_code = nbcp_pkg::CMD_READ_A;
    endcase
  endfunction

  // pointer code for the chosen area
  function automatic logic [7:0] ptr_code(input nbcp_pkg::nbcp_area_type a);
    case (a)
      nbcp_pkg::NBCP_AREA_B: ptr_code = nbcp_pkg::CMD_READ_B;
      nbcp_pkg::NBCP_AREA_C: ptr_code = nbcp_pkg::CMD_READ_C;
      default: ptr_code = nbcp_pkg::CMD_READ_A;
    endcase
  endfunction

  // address byte for cycle n
  function automatic logic [7:0] addr_byte(input logic [1:0] n, input logic [nbcp_pkg::ADDR_W-1:0] a);
    case (n)
      2'd0: addr_byte = a[nbcp_pkg::COL_LSB +: 8];
      2'd1: addr_byte = a[nbcp_pkg::CYC2_LSB +: 8];
      2'd2: addr_byte = a[nbcp_pkg::CYC3_LSB +: 8];
      default: addr_byte = {7'h00, a[nbcp_pkg::TOP_BIT]};
    endcase
  endfunction

  logic is_write_op;
  logic needs_wp;
  logic sends_ptr;
  logic has_addr;
  logic has_confirm;
  assign needs_wp = (op_reg == nbcp_pkg::NBCP_OP_PROG) || (op_reg == nbcp_pkg::NBCP_OP_ERASE)
    || (op_reg == nbcp_pkg::NBCP_OP_COPY);
  assign is_write_op = (op_reg == nbcp_pkg::NBCP_OP_PROG);
  assign sends_ptr = (op_reg == nbcp_pkg::NBCP_OP_PROG) || (op_reg == nbcp_pkg::NBCP_OP_READ);
  assign has_addr = (op_reg != nbcp_pkg::NBCP_OP_STATUS) && (op_reg != nbcp_pkg::NBCP_OP_RESET);
  assign has_confirm = needs_wp;

  // fifos on both data paths
  logic wf_valid;
  logic wf_ready;
  logic [nbcp_pkg::BUS_W-1:0] wf_data;
  logic rf_in_valid;
  logic rf_in_ready;
  logic [nbcp_pkg::BUS_W-1:0] rf_in_data;

  nbcp_fifo #(.WIDTH(nbcp_pkg::BUS_W), .DEPTH(nbcp_pkg::FIFO_DEPTH)) u_wfifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(wdata_valid),
    .in_ready(wdata_ready),
    .in_data(wdata),
    .out_valid(wf_valid),
    .out_ready(wf_ready),
    .out_data(wf_data)
  );

  nbcp_fifo #(.WIDTH(nbcp_pkg::BUS_W), .DEPTH(nbcp_pkg::FIFO_DEPTH)) u_rfifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(rf_in_valid),
    .in_ready(rf_in_ready),
    .in_data(rf_in_data),
    .out_valid(rdata_valid),
    .out_ready(rdata_ready),
    .out_data(rdata)
  );

  // a bus cycle may only start when data or room is there
  logic can_start;
  always_comb begin
    case (state_reg)
      nbcp_state_type'(S_DIN): can_start = wf_valid;
      nbcp_state_type'(S_DOUT): can_start = rf_in_ready;
      default: can_start = 1'b1;
    endcase
  end

  logic bus_state;
  assign bus_state = (state_reg == S_PTR) || (state_reg == S_CMD1) || (state_reg == S_ADDR)
    || (state_reg == S_DIN) || (state_reg == S_CMD2) || (state_reg == S_DOUT);
  logic start_cycle;
  assign start_cycle = bus_state && !strobe_low_reg && (ph_reg == 3'd0) && can_start && !wr_n_reg == 1'b0
    && rd_n_reg;

  // phase counter of the current strobe pulse
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ph_reg <= '0;
      strobe_low_reg <= 1'b0;
    end else if (strobe_low_reg) begin
      // leaving the low phase starts the high recovery count at one
      ph_reg <= ph_end ? 3'd1 : ph_reg + 3'd1;
      strobe_low_reg <= !ph_end;
    end else if (ph_reg != 3'd0) begin
      ph_reg <= ph_end ? 3'd0 : ph_reg + 3'd1;
    end else if (start_cycle) begin
      strobe_low_reg <= 1'b1;
    end
  end

  // recovery after a pulse counts before the next one
  logic rise;
  assign rise = strobe_low_reg && ph_end;

  // strobes: write pulse for input cycles, read pulse for output
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
    end else begin
      wr_n_reg <= !(start_cycle && state_reg != S_DOUT) && !(strobe_low_reg && !ph_end && !wr_n_reg);
      rd_n_reg <= !(start_cycle && state_reg == S_DOUT) && !(strobe_low_reg && !ph_end && !rd_n_reg);
    end
  end

  // latch enables, data drive and chip select per state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cle_reg <= 1'b0;
      ale_reg <= 1'b0;
      oe_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      io_out_reg <= '0;
    end else begin
      cs_n_reg <= (state_reg == S_IDLE) || (state_reg == S_DONE);
      cle_reg <= (state_reg == S_PTR) || (state_reg == S_CMD1) || (state_reg == S_CMD2);
      ale_reg <= (state_reg == S_ADDR);
      oe_reg <= bus_state && (state_reg != S_DOUT);
      case (state_reg)
        S_PTR: io_out_reg <= {8'h00, ptr_code(area_reg)};
        S_CMD1: io_out_reg <= {8'h00, (op_reg == nbcp_pkg::NBCP_OP_READ) ? ptr_code(area_reg)
          : first_code(op_reg)};
        S_ADDR: io_out_reg <= {8'h00, addr_byte(acyc_reg, addr_reg)};
        S_DIN: io_out_reg <= wide_bus ? wf_data : {8'h00, wf_data[7:0]};
        S_CMD2: io_out_reg <= {8'h00, (op_reg == nbcp_pkg::NBCP_OP_ERASE) ? nbcp_pkg::CMD_ERASE_GO
          : (op_reg == nbcp_pkg::NBCP_OP_COPY && !copy_tgt_reg) ? nbcp_pkg::CMD_COPY
          : nbcp_pkg::CMD_PROG_GO};
        default: io_out_reg <= io_out_reg;
      endcase
    end
  end

  // write protect released only for program, erase and copy back
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wp_n_reg <= 1'b0;
    end else begin
      wp_n_reg <= (state_reg != S_IDLE) && (state_reg != S_DONE) && needs_wp;
    end
  end

  assign wf_ready = (state_reg == S_DIN) && rise;
  assign rf_in_valid = (state_reg == S_DOUT) && strobe_low_reg && ph_end;
  assign rf_in_data = wide_bus ? io_in : {8'h00, io_in[7:0]};

  // main sequencer
  logic go;
  assign go = req_valid && req_ready;
  assign req_ready = (state_reg == S_IDLE);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= S_IDLE;
      op_reg <= nbcp_pkg::NBCP_OP_READ;
      area_reg <= nbcp_pkg::NBCP_AREA_A;
      addr_reg <= '0;
      count_reg <= '0;
      acyc_reg <= '0;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      rb_seen_reg <= 1'b0;
      copy_tgt_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      case (state_reg)
        S_IDLE: if (go) begin
          op_reg <= req_op;
          // no area B on a wide bus
          area_reg <= (wide_bus && req_area == nbcp_pkg::NBCP_AREA_B) ? nbcp_pkg::NBCP_AREA_A
            : req_area;
          addr_reg <= req_addr;
          count_reg <= req_count;
          acyc_reg <= '0;
          copy_tgt_reg <= 1'b0;
          // a read carries its pointer code as the first command byte
          state_reg <= (req_op == nbcp_pkg::NBCP_OP_PROG) ? S_PTR : S_CMD1;
        end
        S_PTR: if (rise) begin
          state_reg <= S_CMD1;
        end
        S_CMD1: if (rise) begin
          acyc_reg <= (op_reg == nbcp_pkg::NBCP_OP_ERASE) ? 2'd1 : 2'd0;
          state_reg <= has_addr ? S_ADDR : (op_reg == nbcp_pkg::NBCP_OP_STATUS ? S_DOUT : S_WAIT);
        end
        S_ADDR: if (rise) begin
          acyc_reg <= acyc_reg + 2'd1;
          if (acyc_reg == 2'd3 || (op_reg == nbcp_pkg::NBCP_OP_SIG)) begin
            acyc_reg <= '0;
            state_reg <= is_write_op ? S_DIN
              : (op_reg == nbcp_pkg::NBCP_OP_COPY && !copy_tgt_reg) ? S_WAIT
              : has_confirm ? S_CMD2
              : op_reg == nbcp_pkg::NBCP_OP_SIG ? S_DOUT : S_WAIT;
          end
        end
        S_DIN: if (rise) begin
          count_reg <= count_reg - 9'd1;
          if (count_reg == 9'd1) begin
            state_reg <= S_CMD2;
          end
        end
        S_CMD2: if (rise) begin
          // copy back: code then target address then the 10h confirm
          if (op_reg == nbcp_pkg::NBCP_OP_COPY && !copy_tgt_reg) begin
            copy_tgt_reg <= 1'b1;
            acyc_reg <= 2'd1;
            state_reg <= S_ADDR;
          end else begin
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          rb_seen_reg <= 1'b1;
          if (rb_seen_reg && ready_busy_n) begin
            rb_seen_reg <= 1'b0;
            // copy back: source page loaded, now send the second code
            state_reg <= (op_reg == nbcp_pkg::NBCP_OP_COPY && !copy_tgt_reg) ? S_CMD2
              : (op_reg == nbcp_pkg::NBCP_OP_READ && count_reg != 9'd0) ? S_DOUT : S_DONE;
          end
        end
        S_DOUT: if (rf_in_valid) begin
          count_reg <= count_reg - 9'd1;
          if (count_reg <= 9'd1) begin
            state_reg <= S_DONE;
          end
        end
        S_DONE: begin
          done_reg <= 1'b1;
          copy_tgt_reg <= 1'b0;
          refused_reg <= needs_wp && !write_prot_n;
          // area B lasts one operation
          if (area_reg == nbcp_pkg::NBCP_AREA_B) begin
            area_reg <= nbcp_pkg::NBCP_AREA_A;
          end
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign chip_sel_n = cs_n_reg;
  assign cmd_latch_en = cle_reg;
  assign addr_latch_en = ale_reg;
  assign write_strobe_n = wr_n_reg;
  assign read_strobe_n = rd_n_reg;
  assign write_prot_n = wp_n_reg;
  assign io_oe = oe_reg;
  assign busy = (state_reg != S_IDLE);
  assign done = done_reg;
  assign wp_refused = refused_reg;

  // assertions
  cmd_latch_onehot_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !(cmd_latch_en && addr_latch_en)) else $error("both latches high");
  cmd_strobe_cs_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(write_strobe_n) |-> !chip_sel_n && read_strobe_n) else $error("write rise outside select");
  prog_wp_high_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ($rose(write_strobe_n) && cmd_latch_en && io_out_reg[7:0] == nbcp_pkg::CMD_PROG) |-> write_prot_n)
    else $error("program issued while protected");
  addr_top_clean_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ($rose(write_strobe_n) && addr_latch_en && $past(acyc_reg) == 2'd3) |-> io_out_reg[7:1] == 7'h00)
    else $error("fourth address byte dirty");
  no_b_wide_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ($rose(write_strobe_n) && cmd_latch_en && wide_bus) |-> io_out_reg[7:0] != nbcp_pkg::CMD_READ_B)
    else $error("area b code on wide bus");
  b_revert_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_reg == S_DONE) |=> area_reg != nbcp_pkg::NBCP_AREA_B) else $error("area b kept");
  rd_wr_excl_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !(!write_strobe_n && !read_strobe_n)) else $error("both strobes low");
  idle_desel_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_reg == S_IDLE)[*2] |-> chip_sel_n && !io_oe) else $error("driving while idle");
  prog_cov_c: cover property (@(posedge core_clk) disable iff (!rstn) go && req_op == nbcp_pkg::NBCP_OP_PROG);
  read_cov_c: cover property (@(posedge core_clk) disable iff (!rstn) rf_in_valid);
  done_cov_c: cover property (@(posedge core_clk) disable iff (!rstn) done);
endmodule

// ===== test/nbcp_flash_model.sv
/*
  flash part model: decodes the host's pin levels, logs commands, address
  bytes and data words, answers reads and drives ready/busy.
  assumes the host pins of nbcp_host are wired straight in.
*/
module nbcp_flash_model (
  input wire logic chip_sel_n,
  input wire logic cmd_latch_en,
  input wire logic addr_latch_en,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_prot_n,
  input wire logic [15:0] io_out_reg,
  output logic [15:0] io_in,
  output logic ready_busy_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cmd_q[$];
  logic [7:0] adr_q[$];
  logic [15:0] din_q[$];
  logic [7:0] last_cmd = 8'h00;
  logic [7:0] col = 8'h00;
  logic [1:0] area = 2'h0; // 0 a, 1 b, 2 c; a at power-up
  logic refused = 1'b0;
  int acnt = 0;
  initial begin
    io_in = 16'h0000;
    ready_busy_n = 1'b1;
  end
  // busy span, pull-up returns line high
  task automatic go_busy();
    fork
      begin
        ready_busy_n = 1'b0;
        #600;
        ready_busy_n = 1'b1;
        if (area == 2'h1) area = 2'h0;
      end
    join_none
  endtask
  // write cycles latch on strobe rise while selected
  always @(posedge write_strobe_n) begin
    if (!chip_sel_n && read_strobe_n) begin
      if (cmd_latch_en && !addr_latch_en) begin
        cmd_q.push_back(io_out_reg[7:0]);
        acnt = 0;
        if (ready_busy_n || io_out_reg[7:0] inside {8'h70, 8'hff}) begin
          last_cmd = io_out_reg[7:0];
          case (last_cmd)
            8'h00: area = 2'h0;
            8'h01: area = 2'h1;
            8'h50: area = 2'h2;
            8'hff: begin
              area = 2'h0;
              go_busy();
            end
            8'h10, 8'hd0: begin
              if (write_prot_n) go_busy();
              else refused = 1'b1;
            end
            default: ;
          endcase
        end
      end else if (addr_latch_en && !cmd_latch_en) begin
        if (acnt < 4) adr_q.push_back(io_out_reg[7:0]);
        if (acnt == 0) col = io_out_reg[7:0];
        if (acnt == 3 && last_cmd inside {8'h00, 8'h01, 8'h50}) go_busy();
        acnt++;
      end else if (!cmd_latch_en) din_q.push_back(io_out_reg);
    end
  end
  // each read strobe fall shows the next word
  always @(negedge read_strobe_n) begin
    if (!chip_sel_n && write_strobe_n && !cmd_latch_en && !addr_latch_en) begin
      io_in = {8'h5a, col};
      col++;
    end
  end
  // released bus shows garbage after the hold time
  always @(posedge read_strobe_n or posedge chip_sel_n) begin
    #2;
    io_in = ~io_in;
  end
endmodule

// ===== test/test_nbcp_host.sv
/*
  testbench of nbcp_host: runs program, read, erase and the single-code
  operations against the flash model and checks the pin traffic.
  assumes nbcp_pkg and the design modules are compiled first.
*/
module test_nbcp_host;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  nbcp_pkg::nbcp_op_type req_op = nbcp_pkg::NBCP_OP_READ;
  nbcp_pkg::nbcp_area_type req_area = nbcp_pkg::NBCP_AREA_A;
  logic [25:0] req_addr = 26'h000_0000;
  logic [8:0] req_count = 9'h000;
  logic wide_bus = 1'b0;
  logic wdata_valid = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic rdata_ready = 1'b0;
  logic req_ready, wdata_ready, rdata_valid, busy, done, wp_refused, ready_busy_n;
  logic chip_sel_n, cmd_latch_en, addr_latch_en, write_strobe_n, read_strobe_n, write_prot_n, io_oe;
  logic [15:0] rdata, io_in, io_out_reg;
  int n_fail = 0;
  int check_count = 0;
  int n_done = 0;
  int base = 0;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (done === 1'b1) n_done++;
  nbcp_host dut (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_area(req_area), .req_addr(req_addr), .req_count(req_count), .wide_bus(wide_bus),
    .wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .wdata(wdata), .rdata_valid(rdata_valid),
    .rdata_ready(rdata_ready), .rdata(rdata), .busy(busy), .done(done), .wp_refused(wp_refused),
    .chip_sel_n(chip_sel_n), .cmd_latch_en(cmd_latch_en), .addr_latch_en(addr_latch_en),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .write_prot_n(write_prot_n),
    .ready_busy_n(ready_busy_n), .io_in(io_in), .io_out_reg(io_out_reg), .io_oe(io_oe));
  nbcp_flash_model fm (.chip_sel_n(chip_sel_n), .cmd_latch_en(cmd_latch_en), .addr_latch_en(addr_latch_en),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .write_prot_n(write_prot_n),
    .io_out_reg(io_out_reg), .io_in(io_in), .ready_busy_n(ready_busy_n));
  task automatic results();
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one request, taken while idle
  task automatic issue(input nbcp_pkg::nbcp_op_type op, input nbcp_pkg::nbcp_area_type ar,
                       input logic [25:0] a, input logic [8:0] n);
    int t;
    t = 0;
    fm.cmd_q.delete();
    fm.adr_q.delete();
    fm.din_q.delete();
    base = n_done;
    req_op = op;
    req_area = ar;
    req_addr = a;
    req_count = n;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && t < 100) begin
      @(posedge core_clk);
      #1;
      t++;
    end
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
  endtask
  task automatic finish();
    int t;
    t = 0;
    while (n_done == base && t < 20000) begin
      @(posedge core_clk);
      #1;
      t++;
    end
    chk({15'h0000, n_done != base}, 16'h0001);
  endtask
  task automatic chk_adr(input logic [25:0] a, input int first);
    logic [7:0] e[4];
    e = '{a[7:0], a[16:9], a[24:17], {7'h00, a[25]}};
    chk(16'(fm.adr_q.size()), 16'(4 - first));
    for (int k = first; k < 4; k++) chk({8'h00, fm.adr_q[k - first]}, {8'h00, e[k]});
  endtask
  task automatic drain(input int n, input logic [7:0] c0, input logic wide);
    int t;
    rdata_ready = 1'b1;
    for (int k = 0; k < n; k++) begin
      t = 0;
      while (rdata_valid !== 1'b1 && t < 2000) begin
        @(posedge core_clk);
        #1;
        t++;
      end
      if (wide) chk(rdata, {8'h5a, c0 + 8'(k)});
      else chk({8'h00, rdata[7:0]}, {8'h00, c0 + 8'(k)});
      @(posedge core_clk);
      #1;
    end
  endtask
  // fifo filled until refused, then programmed into area b
  task automatic prog_area_b();
    wdata_valid = 1'b1;
    for (int k = 0; k < 17; k++) begin
      wdata = {8'hc3, 8'h30 + 8'(k)};
      if (k < 16) @(posedge core_clk);
      if (k < 16) #1;
    end
    chk({15'h0000, wdata_ready}, 16'h0000);
    wdata_valid = 1'b0;
    issue(nbcp_pkg::NBCP_OP_PROG, nbcp_pkg::NBCP_AREA_B, 26'h2ab_cd17, 9'h010);
    finish();
    chk({fm.cmd_q[0], fm.cmd_q[1]}, 16'h0180);
    chk({8'h00, fm.cmd_q[2]}, 16'h0010);
    chk_adr(26'h2ab_cd17, 0);
    for (int k = 0; k < 16; k++) chk({8'h00, fm.din_q[k][7:0]}, {8'h00, 8'h30 + 8'(k)});
    chk({14'h0000, fm.area}, 16'h0000);
    chk({15'h0000, write_prot_n}, 16'h0000);
  endtask
  // spare area read stalls on full fifo, then drains
  task automatic read_area_c();
    rdata_ready = 1'b0;
    issue(nbcp_pkg::NBCP_OP_READ, nbcp_pkg::NBCP_AREA_C, 26'h155_3203, 9'h014);
    repeat (400) @(posedge core_clk);
    #1;
    chk({15'h0000, busy}, 16'h0001);
    drain(20, 8'h03, 1'b0);
    finish();
    chk({8'h00, fm.cmd_q[0]}, 16'h0050);
    chk_adr(26'h155_3203, 0);
    chk({14'h0000, fm.area}, 16'h0002);
  endtask
  task automatic erase_block();
    issue(nbcp_pkg::NBCP_OP_ERASE, nbcp_pkg::NBCP_AREA_A, 26'h3c0_4e00, 9'h000);
    finish();
    chk({fm.cmd_q[0], fm.cmd_q[1]}, 16'h60d0);
    chk_adr(26'h3c0_4e00, 1);
    chk({15'h0000, fm.refused}, 16'h0000);
  endtask
  // single-code operations and copy back
  task automatic code_table();
    nbcp_pkg::nbcp_op_type ops[4];
    logic [7:0] codes[4];
    ops = '{nbcp_pkg::NBCP_OP_COPY, nbcp_pkg::NBCP_OP_SIG, nbcp_pkg::NBCP_OP_STATUS, nbcp_pkg::NBCP_OP_RESET};
    codes = '{8'h00, 8'h90, 8'h70, 8'hff};
    rdata_ready = 1'b1;
    for (int k = 0; k < 4; k++) begin
      issue(ops[k], nbcp_pkg::NBCP_AREA_A, 26'h044_2200, 9'h002);
      finish();
      chk({8'h00, fm.cmd_q[0]}, {8'h00, codes[k]});
      if (k == 0) chk({fm.cmd_q[1], fm.cmd_q[2]}, 16'h8a10);
    end
    chk({14'h0000, fm.area}, 16'h0000);
  endtask
  // wide part never gets the second-half pointer
  task automatic wide_read_b();
    wide_bus = 1'b1;
    issue(nbcp_pkg::NBCP_OP_READ, nbcp_pkg::NBCP_AREA_B, 26'h001_0a40, 9'h002);
    drain(2, 8'h40, 1'b1);
    finish();
    chk({8'h00, fm.cmd_q[0]}, 16'h0000);
    wide_bus = 1'b0;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    chk({chip_sel_n, write_prot_n, io_oe, 13'h0000}, 16'h8000);
    rstn = 1'b1;
    prog_area_b();
    read_area_c();
    erase_block();
    code_table();
    wide_read_b();
    results();
  end
  // watchdog
  initial begin
    #500000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
endmodule
